// >>> inc/io_mux_pkg.sv
// package for the port function multiplexer: pin map, mode codes, carriers.
// assumes one cpu clock domain; all users import the whole package.
package io_mux_pkg;

   // pin map of the flat pad vector
   localparam int PIN_COUNT = 38;
   localparam int P0_BASE = 0;
   localparam int P1_BASE = 8;
   localparam int P2_BASE = 16;
   localparam int P3_BASE = 24;
   localparam int P4_BASE = 32;
   localparam int PORT_WIDTH = 8;
   localparam int P4_WIDTH = 6;

   // port 1 pin positions
   localparam int P1_CARD_IO = 0;
   localparam int P1_CARD_C8 = 1;
   localparam int P1_PRESENCE = 2;
   localparam int P1_CARD_C4 = 3;
   localparam int P1_CARD_CLK = 4;
   localparam int P1_CARD_RST = 5;
   localparam int P1_SLAVE_SEL = 6;
   localparam int P1_ALT_CLK = 7;

   // port 3 pin positions
   localparam int P3_RXD = 0;
   localparam int P3_TXD = 1;
   localparam int P3_IRQ0 = 2;
   localparam int P3_IRQ1 = 3;
   localparam int P3_T0 = 4;
   localparam int P3_T1 = 5;
   localparam int P3_WR = 6;
   localparam int P3_RD = 7;

   // mode register select and field positions
   localparam logic MODE_SEL_REG0 = 1'b0;
   localparam logic MODE_SEL_REG1 = 1'b1;
   localparam int M0_P0_LSB = 0;
   localparam int M0_PRES_BIT = 3;
   localparam int M0_P2_LSB = 4;
   localparam int M0_P3_LSB = 6;
   localparam int M1_P4_LSB = 0;
   localparam int M1_LED_LSB = 4;
   localparam logic [7:0] MODE_REG0_RESET = 8'h00;
   localparam logic [7:0] MODE_REG1_RESET = 8'h00;

   // two-bit configuration codes
   localparam logic [1:0] CFG_DEFAULT = 2'h0;
   localparam logic [1:0] CFG_ONE = 2'h1;
   localparam logic [1:0] CFG_TWO = 2'h2;
   localparam logic [1:0] CFG_THREE = 2'h3;

   typedef enum logic [2:0] {
      DRV_OPEN_DRAIN,
      DRV_QUASI,
      DRV_PUSH_PULL,
      DRV_LOW_SPEED_KEYBOARD_OUTPUT,
      DRV_WPU_INPUT,
      DRV_INPUT,
      DRV_LED
   } drive_mode_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic weakPu;
      logic mediumPu;
      logic slowSlew;
      logic ledDrive;
   } pad_ctrl_t;

   typedef struct packed {
      logic en;
      logic sel;
      logic [7:0] data;
   } mode_write_t;

   typedef struct packed {
      logic active;
      logic addrDataOe;
      logic [7:0] addrData;
      logic [7:0] addrHigh;
      logic wrStrobeN;
      logic rdStrobeN;
   } ext_bus_t;

   typedef struct packed {
      logic active;
      logic ioOut;
      logic c4Out;
      logic c8Out;
      logic clk;
      logic rst;
   } card_out_t;

   typedef struct packed {
      logic syncMode;
      logic dataOutEn;
      logic dataOut;
      logic txdOrClk;
   } serial_out_t;

endpackage

// >>> verilog/io_pad_ctrl.sv
// one pad's drive decode: drive kind, output value and pin level to pad controls.
// assumes the caller registers the result before it reaches a pin.
`timescale 1ns/10ps
module io_pad_ctrl
   import io_mux_pkg::*;
(
   input wire io_mux_pkg::drive_mode_t mode,
   input wire logic value,
   input wire logic pinIn,
   input wire logic weakDisable,
   input wire logic mediumDisable,
   output io_mux_pkg::pad_ctrl_t pad
);
   always_comb begin
      pad = '0;
      case (mode)
         DRV_OPEN_DRAIN: begin
            // a one floats; only zeros are driven
            pad.oe = ~value;
         end
         DRV_QUASI: begin
            pad.oe = ~value;
            pad.weakPu = value & ~weakDisable;
            // medium pull-up follows the pin so an outside device can win
            pad.mediumPu = value & pinIn & ~mediumDisable;
         end
         DRV_PUSH_PULL: begin
            pad.oe = 1'b1;
            pad.out = value;
         end
         DRV_LOW_SPEED_KEYBOARD_OUTPUT: begin
            pad.oe = 1'b1;
            pad.out = value;
            pad.slowSlew = 1'b1;
         end
         DRV_WPU_INPUT: begin
            pad.weakPu = 1'b1;
         end
         DRV_LED: begin
            pad.oe = 1'b1;
            pad.out = value;
            pad.ledDrive = 1'b1;
         end
         default: begin
            pad = '0;
         end
      endcase
   end
endmodule

// >>> verilog/io_port_function_mux.sv
// function and drive-mode multiplexer for general ports 0 to 4 (38 pads).
// assumes port latches, external bus, serial and card signals come from the cpu clock domain.
`timescale 1ns/10ps
module io_port_function_mux (
   input wire logic clk,
   input wire logic rst_n,
   input wire io_mux_pkg::mode_write_t modeWr,
   input wire logic weakPullupDisable,
   input wire logic altCardClockEnable,
   input wire logic altCardClockOutput,
   input wire logic [7:0] p0Latch,
   input wire logic [7:0] p1Latch,
   input wire logic [7:0] p2Latch,
   input wire logic [7:0] p3Latch,
   input wire logic [5:0] p4Latch,
   input wire io_mux_pkg::ext_bus_t extBus,
   input wire io_mux_pkg::card_out_t card,
   input wire io_mux_pkg::serial_out_t serial,
   input wire logic [37:0] pinIn,
   output logic [37:0] padOut,
   output logic [37:0] padOe,
   output logic [37:0] padWeakPu,
   output logic [37:0] padMediumPu,
   output logic [37:0] padSlowSlew,
   output logic [37:0] padLedDrive,
   output logic [37:0] pinSample,
   output logic [7:0] portModeReg0,
   output logic [7:0] portModeReg1,
   output logic serialRxIn,
   output logic extIrqZeroInput,
   output logic extIrqOneInput,
   output logic timerZeroCountInput,
   output logic timerOneCountInput,
   output logic spiSlaveSelect,
   output logic cardPresenceInput,
   output logic cardIoIn,
   output logic cardContactFourIn,
   output logic cardContactEightIn
);
   import io_mux_pkg::*;

   // port 0 codes: config 1 is not defined, so it stays open drain
   function automatic drive_mode_t port0Decode(input logic [1:0] cfg);
      drive_mode_t m;
      m = DRV_OPEN_DRAIN;
      case (cfg)
         CFG_TWO: m = DRV_LOW_SPEED_KEYBOARD_OUTPUT;
         CFG_THREE: m = DRV_PUSH_PULL;
         default: m = DRV_OPEN_DRAIN;
      endcase
      return m;
   endfunction

   // ports 2, 3 and 4 share one code set
   function automatic drive_mode_t stdDecode(input logic [1:0] cfg);
      drive_mode_t m;
      m = DRV_QUASI;
      case (cfg)
         CFG_ONE: m = DRV_PUSH_PULL;
         CFG_TWO: m = DRV_LOW_SPEED_KEYBOARD_OUTPUT;
         CFG_THREE: m = DRV_WPU_INPUT;
         default: m = DRV_QUASI;
      endcase
      return m;
   endfunction

   logic [7:0] modeReg0;
   logic [7:0] modeReg1;
   logic [7:0] next_modeReg0;
   logic [7:0] next_modeReg1;

   // software writes replace a whole register; reset means defaults everywhere
   assign next_modeReg0 = (modeWr.en && modeWr.sel == MODE_SEL_REG0) ? modeWr.data : modeReg0;
   assign next_modeReg1 = (modeWr.en && modeWr.sel == MODE_SEL_REG1) ? modeWr.data : modeReg1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeReg0 <= MODE_REG0_RESET;
         modeReg1 <= MODE_REG1_RESET;
      end else begin
         modeReg0 <= next_modeReg0;
         modeReg1 <= next_modeReg1;
      end
   end

   wire [1:0] p0Cfg = modeReg0[M0_P0_LSB +: 2];
   wire [1:0] p2Cfg = modeReg0[M0_P2_LSB +: 2];
   wire [1:0] p3Cfg = modeReg0[M0_P3_LSB +: 2];
   wire [1:0] p4Cfg = modeReg1[M1_P4_LSB +: 2];
   wire [3:0] ledEnable = modeReg1[M1_LED_LSB +: 4];
   wire presenceDisconnect = modeReg0[M0_PRES_BIT];

   drive_mode_t pinMode [PIN_COUNT];
   logic [37:0] pinValue;
   logic [37:0] weakDis;
   logic [37:0] mediumDis;
   pad_ctrl_t padNext [PIN_COUNT];

   // port 0: address low / data during external accesses, else latch
   wire drive0Bus = extBus.active & extBus.addrDataOe;
   wire drive0Mode = drive0Bus ? 1'b1 : 1'b0;
   genvar i;
   generate
      for (i = 0; i < PORT_WIDTH; i = i + 1) begin : g_port0
         // a bus cycle with addrDataOe set drives ones strongly instead of floating them
         assign pinMode[P0_BASE + i] = extBus.active ?
            (drive0Mode ? DRV_PUSH_PULL : DRV_INPUT) : port0Decode(p0Cfg);
         assign pinValue[P0_BASE + i] = extBus.active ? extBus.addrData[i] : p0Latch[i];
         assign weakDis[P0_BASE + i] = weakPullupDisable;
         assign mediumDis[P0_BASE + i] = 1'b0;
      end
   endgenerate

   // port 1: card contacts follow the card block and stay low while it is idle
   wire cardIoVal = card.active & card.ioOut;
   wire cardC4Val = card.active & card.c4Out;
   wire cardC8Val = card.active & card.c8Out;
   wire cardClkVal = card.active & card.clk;
   wire cardRstVal = card.active & card.rst;

   assign pinMode[P1_BASE + P1_CARD_IO] = DRV_QUASI;
   assign pinValue[P1_BASE + P1_CARD_IO] = cardIoVal;
   assign pinMode[P1_BASE + P1_CARD_C8] = DRV_QUASI;
   assign pinValue[P1_BASE + P1_CARD_C8] = cardC8Val;
   assign pinMode[P1_BASE + P1_CARD_C4] = DRV_QUASI;
   assign pinValue[P1_BASE + P1_CARD_C4] = cardC4Val;
   assign pinMode[P1_BASE + P1_CARD_CLK] = DRV_PUSH_PULL;
   assign pinValue[P1_BASE + P1_CARD_CLK] = cardClkVal;
   assign pinMode[P1_BASE + P1_CARD_RST] = DRV_PUSH_PULL;
   assign pinValue[P1_BASE + P1_CARD_RST] = cardRstVal;
   // presence is released high; the card socket switch pulls it down
   assign pinMode[P1_BASE + P1_PRESENCE] = DRV_QUASI;
   assign pinValue[P1_BASE + P1_PRESENCE] = p1Latch[P1_PRESENCE];
   assign pinMode[P1_BASE + P1_SLAVE_SEL] = DRV_QUASI;
   assign pinValue[P1_BASE + P1_SLAVE_SEL] = p1Latch[P1_SLAVE_SEL];
   assign pinMode[P1_BASE + P1_ALT_CLK] = altCardClockEnable ? DRV_PUSH_PULL : DRV_QUASI;
   assign pinValue[P1_BASE + P1_ALT_CLK] = altCardClockEnable ? altCardClockOutput : p1Latch[P1_ALT_CLK];

   generate
      for (i = 0; i < PORT_WIDTH; i = i + 1) begin : g_port1_pull
         if (i == P1_PRESENCE) begin : g_pres
            assign weakDis[P1_BASE + i] = presenceDisconnect;
            assign mediumDis[P1_BASE + i] = presenceDisconnect;
         end else begin : g_other
            assign weakDis[P1_BASE + i] = weakPullupDisable;
            assign mediumDis[P1_BASE + i] = 1'b0;
         end
      end
   endgenerate

   // port 2: high address during external accesses
   generate
      for (i = 0; i < PORT_WIDTH; i = i + 1) begin : g_port2
         assign pinMode[P2_BASE + i] = extBus.active ? DRV_PUSH_PULL : stdDecode(p2Cfg);
         assign pinValue[P2_BASE + i] = extBus.active ? extBus.addrHigh[i] : p2Latch[i];
         assign weakDis[P2_BASE + i] = weakPullupDisable;
         assign mediumDis[P2_BASE + i] = 1'b0;
      end
   endgenerate

   // port 3: alternate outputs are anded with the latch, idle alternates sit at one
   logic [7:0] p3Alt;
   logic [7:0] p3Led;
   always_comb begin
      p3Alt = 8'hFF;
      p3Alt[P3_RXD] = (serial.syncMode & serial.dataOutEn) ? serial.dataOut : 1'b1;
      p3Alt[P3_TXD] = serial.txdOrClk;
      p3Alt[P3_WR] = extBus.active ? extBus.wrStrobeN : 1'b1;
      p3Alt[P3_RD] = extBus.active ? extBus.rdStrobeN : 1'b1;
      p3Led = 8'h00;
      p3Led[P3_IRQ0] = ledEnable[0];
      p3Led[P3_T0] = ledEnable[1];
      p3Led[P3_WR] = ledEnable[2];
      p3Led[P3_RD] = ledEnable[3];
   end

   generate
      for (i = 0; i < PORT_WIDTH; i = i + 1) begin : g_port3
         assign pinMode[P3_BASE + i] = p3Led[i] ? DRV_LED : stdDecode(p3Cfg);
         assign pinValue[P3_BASE + i] = p3Latch[i] & p3Alt[i];
         assign weakDis[P3_BASE + i] = weakPullupDisable;
         assign mediumDis[P3_BASE + i] = 1'b0;
      end
   endgenerate

   // port 4: six plain pins
   generate
      for (i = 0; i < P4_WIDTH; i = i + 1) begin : g_port4
         assign pinMode[P4_BASE + i] = stdDecode(p4Cfg);
         assign pinValue[P4_BASE + i] = p4Latch[i];
         assign weakDis[P4_BASE + i] = weakPullupDisable;
         assign mediumDis[P4_BASE + i] = 1'b0;
      end
   endgenerate

   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pad
         io_pad_ctrl u_pad (
            .mode(pinMode[i]),
            .value(pinValue[i]),
            .pinIn(pinIn[i]),
            .weakDisable(weakDis[i]),
            .mediumDisable(mediumDis[i]),
            .pad(padNext[i])
         );
      end
   endgenerate

   // every pad control is registered, so pins move one clock after their cause
   generate
      for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_padreg
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               // reset values match the default modes: card pins low, presence released high
               padOut[i] <= 1'b0;
               padOe[i] <= (i >= P1_BASE + P1_CARD_IO && i <= P1_BASE + P1_CARD_RST && i != P1_BASE + P1_PRESENCE);
               padWeakPu[i] <= (i >= P1_BASE && i < P1_BASE + PORT_WIDTH) ?
                  !(i != P1_BASE + P1_PRESENCE && i <= P1_BASE + P1_CARD_RST) :
                  (i >= P2_BASE);
               padMediumPu[i] <= 1'b0;
               padSlowSlew[i] <= 1'b0;
               padLedDrive[i] <= 1'b0;
            end else begin
               padOut[i] <= padNext[i].out;
               padOe[i] <= padNext[i].oe;
               padWeakPu[i] <= padNext[i].weakPu;
               padMediumPu[i] <= padNext[i].mediumPu;
               padSlowSlew[i] <= padNext[i].slowSlew;
               padLedDrive[i] <= padNext[i].ledDrive;
            end
         end
      end
   endgenerate

   // pin levels back to the core and to the peripherals; inputs are already synchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSample <= '1;
         portModeReg0 <= MODE_REG0_RESET;
         portModeReg1 <= MODE_REG1_RESET;
         serialRxIn <= 1'b1;
         extIrqZeroInput <= 1'b1;
         extIrqOneInput <= 1'b1;
         timerZeroCountInput <= 1'b1;
         timerOneCountInput <= 1'b1;
         spiSlaveSelect <= 1'b1;
         cardPresenceInput <= 1'b1;
         cardIoIn <= 1'b0;
         cardContactFourIn <= 1'b0;
         cardContactEightIn <= 1'b0;
      end else begin
         pinSample <= pinIn;
         portModeReg0 <= next_modeReg0;
         portModeReg1 <= next_modeReg1;
         serialRxIn <= pinIn[P3_BASE + P3_RXD];
         // the interrupt and timer count inputs each come from their own port 3 pin
         extIrqZeroInput <= pinIn[P3_BASE + P3_IRQ0];
         extIrqOneInput <= pinIn[P3_BASE + P3_IRQ1];
         timerZeroCountInput <= pinIn[P3_BASE + P3_T0];
         timerOneCountInput <= pinIn[P3_BASE + P3_T1];
         spiSlaveSelect <= pinIn[P1_BASE + P1_SLAVE_SEL];
         cardPresenceInput <= pinIn[P1_BASE + P1_PRESENCE];
         cardIoIn <= pinIn[P1_BASE + P1_CARD_IO];
         cardContactFourIn <= pinIn[P1_BASE + P1_CARD_C4];
         cardContactEightIn <= pinIn[P1_BASE + P1_CARD_C8];
      end
   end

endmodule

// >>> verif/io_port_function_mux_assertions.sv
// checker for the port function multiplexer: pad decode against its causes.
// assumes a bind into io_port_function_mux; pads lag their inputs by one clock.
`timescale 1ns/10ps
module io_port_function_mux_assertions
   import io_mux_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic weakPullupDisable,
   input wire logic altCardClockEnable,
   input wire logic altCardClockOutput,
   input wire logic [7:0] p0Latch,
   input wire logic [7:0] p2Latch,
   input wire logic [7:0] p3Latch,
   input wire io_mux_pkg::ext_bus_t extBus,
   input wire io_mux_pkg::card_out_t card,
   input wire logic [37:0] pinIn,
   input wire logic [37:0] padOut,
   input wire logic [37:0] padOe,
   input wire logic [37:0] padWeakPu,
   input wire logic [37:0] padMediumPu,
   input wire logic [37:0] padSlowSlew,
   input wire logic [37:0] padLedDrive,
   input wire logic [7:0] portModeReg0,
   input wire logic [7:0] portModeReg1,
   input wire logic serialRxIn,
   input wire logic extIrqZeroInput,
   input wire logic spiSlaveSelect
);
   logic live;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // $past still sees reset-time inputs at the first edge after release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live <= 1'b0;
      end else begin
         live <= 1'b1;
      end
   end
   p0_open_drain_a:
      assert property (live && !$past(extBus.active) && !$past(portModeReg0[1]) |->
         padOe[7:0] == ~$past(p0Latch) && padOut[7:0] == 8'h00) else $error("port 0 open drain wrong");
   p0_low_speed_keyboard_output_a:
      assert property (live && !$past(extBus.active) && $past(portModeReg0[1:0]) == CFG_TWO |->
         padSlowSlew[7:0] == 8'hFF && padOut[7:0] == $past(p0Latch)) else $error("port 0 slow output wrong");
   ext_addr_bus_a:
      assert property (extBus.active && extBus.addrDataOe |=> padOe[7:0] == 8'hFF && padOe[23:16] == 8'hFF
         && padOut[7:0] == $past(extBus.addrData) && padOut[23:16] == $past(extBus.addrHigh))
         else $error("external address drive wrong");
   p2_quasi_pull_a:
      assert property (live && !$past(extBus.active) && $past(portModeReg0[5:4]) == CFG_DEFAULT |->
         padWeakPu[23:16] == ($past(p2Latch) & ~{8{$past(weakPullupDisable)}})) else $error("port 2 pull-up wrong");
   card_idle_low_a:
      assert property (!card.active ##1 1'b1 |-> padOe[13:11] == 3'h7 && padOe[9:8] == 2'h3
         && padOut[13:11] == 3'h0 && padOut[9:8] == 2'h0) else $error("idle card lines not low");
   presence_pull_off_a:
      assert property ($past(portModeReg0[3]) && live |-> !padWeakPu[10] && !padMediumPu[10])
         else $error("presence pull-ups still on");
   alt_clock_drive_a:
      assert property (altCardClockEnable |=> padOe[15] && padOut[15] == $past(altCardClockOutput))
         else $error("alternate clock not driven");
   write_strobe_a:
      assert property (extBus.active && portModeReg0[7:6] == CFG_DEFAULT && !portModeReg1[6] |=>
         padOe[30] == !($past(p3Latch[6]) && $past(extBus.wrStrobeN))) else $error("write strobe wrong");
   led_drive_a:
      assert property (portModeReg1[4] |=> padLedDrive[26] && padOe[26] && padOut[26] == $past(p3Latch[2]))
         else $error("led drive wrong");
   input_sample_a:
      assert property (live |-> serialRxIn == $past(pinIn[24]) && extIrqZeroInput == $past(pinIn[26])
         && spiSlaveSelect == $past(pinIn[14])) else $error("sampled input wrong");
   cover property (live && extBus.active && !extBus.wrStrobeN);
   cover property (live && altCardClockEnable);
   cover property (live && portModeReg1[7:4] == 4'hF);
endmodule
bind io_port_function_mux io_port_function_mux_assertions i_chk (.clk, .rst_n, .weakPullupDisable,
   .altCardClockEnable, .altCardClockOutput, .p0Latch, .p2Latch, .p3Latch, .extBus, .card, .pinIn, .padOut,
   .padOe, .padWeakPu, .padMediumPu, .padSlowSlew, .padLedDrive, .portModeReg0, .portModeReg1, .serialRxIn,
   .extIrqZeroInput, .spiSlaveSelect);

// >>> verif/io_board_model.sv
// board around the pads: resolves every pin, and an external memory latching port 0.
// assumes padOe means a strong drive, which wins over any board driver.
`timescale 1ns/10ps
module io_board_model (
   input wire logic clk,
   input wire logic [37:0] padOut,
   input wire logic [37:0] padOe,
   input wire logic [37:0] padWeakPu,
   input wire logic [37:0] padMediumPu,
   input wire logic [37:0] boardOe,
   input wire logic [37:0] boardVal,
   output logic [37:0] pinIn,
   output logic [7:0] memByte
);
   logic wander;
   initial wander = 1'b0;
   initial memByte = 8'h00;
   // a floating line toggles so a stale level never passes for a pull-up
   always @(posedge clk) wander <= ~wander;
   assign pinIn = (padOe & padOut) | (~padOe & boardOe & boardVal)
      | (~padOe & ~boardOe & (padWeakPu | padMediumPu | {38{wander}}));
   always @(posedge pinIn[30]) memByte <= pinIn[7:0];
endmodule

// >>> verif/io_port_function_mux_tb_top.sv
// self-checking bench for the port function multiplexer: modes, bus, card and inputs.
// assumes the board model resolves pins; checks wait out one clock of pad latency.
`timescale 1ns/10ps
module io_port_function_mux_tb_top;
   import io_mux_pkg::*;
   logic clk, rst_n, weakPullupDisable, altCardClockEnable, altCardClockOutput;
   mode_write_t modeWr;
   logic [7:0] p0Latch, p1Latch, p2Latch, p3Latch, portModeReg0, portModeReg1, memByte;
   logic [5:0] p4Latch;
   ext_bus_t extBus;
   card_out_t card;
   serial_out_t serial;
   logic [37:0] pinIn, padOut, padOe, padWeakPu, padMediumPu, padSlowSlew, padLedDrive, pinSample, boardOe, boardVal;
   logic serialRxIn, extIrqZeroInput, extIrqOneInput, timerZeroCountInput, timerOneCountInput;
   logic spiSlaveSelect, cardPresenceInput, cardIoIn, cardContactFourIn, cardContactEightIn;
   logic [15:0] e;
   int failures;
   int cmpCount;
   io_port_function_mux i_dut (.clk, .rst_n, .modeWr, .weakPullupDisable, .altCardClockEnable,
      .altCardClockOutput, .p0Latch, .p1Latch, .p2Latch, .p3Latch, .p4Latch, .extBus, .card, .serial, .pinIn,
      .padOut, .padOe, .padWeakPu, .padMediumPu, .padSlowSlew, .padLedDrive, .pinSample, .portModeReg0,
      .portModeReg1, .serialRxIn, .extIrqZeroInput, .extIrqOneInput, .timerZeroCountInput, .timerOneCountInput,
      .spiSlaveSelect, .cardPresenceInput, .cardIoIn, .cardContactFourIn, .cardContactEightIn);
   io_board_model i_board (.clk, .padOut, .padOe, .padWeakPu, .padMediumPu, .boardOe, .boardVal, .pinIn, .memByte);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input string what, input logic [37:0] seen, input logic [37:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // two edges: one to take the inputs, one more for a mode write to reach the pads
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic set_mode(input logic sel, input logic [7:0] data);
      modeWr = '{en: 1'b1, sel: sel, data: data};
      @(posedge clk);
      #1;
      modeWr.en = 1'b0;
      // one idle edge so a following write never re-raises en in the same step
      @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] quasi_exp(input int c, input logic [7:0] l);
      case (c)
         0: return {~l, 8'h00};
         3: return 16'h0000;
         default: return {8'hFF, l};
      endcase
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      modeWr = '0;
      {weakPullupDisable, altCardClockEnable, altCardClockOutput} = 3'h0;
      {p0Latch, p1Latch, p2Latch, p3Latch, p4Latch} = '1;
      extBus = '0;
      card = '0;
      serial = '{syncMode: 1'b0, dataOutEn: 1'b0, dataOut: 1'b0, txdOrClk: 1'b1};
      boardOe = '0;
      boardVal = '0;
      repeat (8) @(posedge clk);
      #1;
      check("reset modes", {portModeReg1, portModeReg0}, 16'h0000);
      check("reset oe", padOe, 38'h0000003B00);
      check("reset out", padOut, '0);
      check("reset pull", padWeakPu, 38'h3FFFFFC400);
      check("reset card in", {cardIoIn, cardPresenceInput}, 2'b01);
      rst_n = 1'b1;
      settle();
      check("p0 float", padOe[7:0], 8'h00);
      p0Latch = 8'hA5;
      for (int c = 0; c < 4; c++) begin
         set_mode(MODE_SEL_REG0, 8'(c));
         settle();
         check("mode reg", portModeReg0, 8'(c));
         check("p0 oe", padOe[7:0], c < 2 ? {~p0Latch} : 8'hFF);
         check("p0 out", padOut[7:0], c < 2 ? 8'h00 : p0Latch);
         check("p0 slew", padSlowSlew[7:0], c == 2 ? 8'hFF : 8'h00);
      end
      {p0Latch, p2Latch, p3Latch, p4Latch} = {8'hFF, 8'h5A, 8'h5A, 6'h1A};
      for (int c = 0; c < 4; c++) begin
         set_mode(MODE_SEL_REG0, {2'(c), 2'(c), 4'h0});
         set_mode(MODE_SEL_REG1, {6'h00, 2'(c)});
         settle();
         check("p2", {padOe[23:16], padOut[23:16]}, quasi_exp(c, p2Latch));
         check("p3", {padOe[31:24], padOut[31:24]}, quasi_exp(c, p3Latch));
         e = quasi_exp(c, {2'b00, p4Latch});
         check("p4", {padOe[37:32], padOut[37:32]}, {e[13:8], e[5:0]});
         check("mode reg1", portModeReg1, {6'h00, 2'(c)});
         if (c == 0 || c == 3) check("p2 pull", padWeakPu[23:16], c == 3 ? 8'hFF : p2Latch);
      end
      set_mode(MODE_SEL_REG0, 8'h00);
      set_mode(MODE_SEL_REG1, 8'h00);
      weakPullupDisable = 1'b1;
      settle();
      check("pull off", padWeakPu[23:16], 8'h00);
      extBus = '{active: 1'b1, addrDataOe: 1'b1, addrData: 8'h96, addrHigh: 8'h3C, wrStrobeN: 1'b0, rdStrobeN: 1'b1};
      {weakPullupDisable, p3Latch} = {1'b0, 8'hFF};
      settle();
      check("ext low", {padOe[7:0], padOut[7:0]}, 16'hFF96);
      check("ext high", {padOe[23:16], padOut[23:16]}, 16'hFF3C);
      check("strobes", padOe[31:30], 2'b01);
      {extBus.wrStrobeN, extBus.rdStrobeN} = 2'b10;
      settle();
      check("mem latch", memByte, 8'h96);
      check("read strobe", padOe[31:30], 2'b10);
      extBus.addrDataOe = 1'b0;
      settle();
      check("ext input", padOe[7:0], 8'h00);
      extBus = '0;
      card = '{active: 1'b1, ioOut: 1'b1, c4Out: 1'b1, c8Out: 1'b0, clk: 1'b1, rst: 1'b1};
      weakPullupDisable = 1'b1;
      settle();
      check("card oe", padOe[13:8], 6'h32);
      check("card out", padOut[13:8], 6'h30);
      check("card pull", {padWeakPu[11], padWeakPu[8]}, 2'b00);
      {card, weakPullupDisable} = '0;
      set_mode(MODE_SEL_REG0, 8'h08);
      settle();
      check("presence off", {padWeakPu[10], padMediumPu[10]}, 2'b00);
      set_mode(MODE_SEL_REG0, 8'h00);
      settle();
      check("presence on", padWeakPu[10], 1'b1);
      altCardClockEnable = 1'b1;
      for (int v = 0; v < 2; v++) begin
         altCardClockOutput = v[0];
         settle();
         check("alt clk", {padOe[15], padOut[15]}, {1'b1, v[0]});
      end
      {altCardClockEnable, p1Latch} = 9'h000;
      settle();
      check("p1 low", {padOe[15:14], padOut[15:14]}, 4'hC);
      p1Latch = 8'hFF;
      boardOe = 38'h003D004400;
      for (int v = 0; v < 2; v++) begin
         boardVal = {38{v[0]}};
         settle();
         check("inputs", {serialRxIn, extIrqZeroInput, extIrqOneInput, timerZeroCountInput,
            timerOneCountInput, spiSlaveSelect, cardPresenceInput}, {7{v[0]}});
         check("pin sample", pinSample[31:24], v[0] ? 8'hFF : 8'hC2);
         check("medium pull", padMediumPu[14], v[0]);
         check("card in", {cardIoIn, cardContactFourIn, cardContactEightIn}, 3'h0);
      end
      boardOe = '0;
      serial = '{syncMode: 1'b1, dataOutEn: 1'b1, dataOut: 1'b0, txdOrClk: 1'b0};
      settle();
      check("serial drive", padOe[25:24], 2'b11);
      serial = '{syncMode: 1'b0, dataOutEn: 1'b0, dataOut: 1'b0, txdOrClk: 1'b1};
      set_mode(MODE_SEL_REG1, 8'hF0);
      settle();
      check("led", padLedDrive, 38'h00D4000000);
      check("led oe", padOe[31:24], 8'hD4);
      rst_n = 1'b0;
      #5;
      check("mid reset", {portModeReg1, portModeReg0}, 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      settle();
      check("default again", {padLedDrive[31:24], padWeakPu[31:16]}, 24'h00FF5A);
      report_and_stop();
   end
endmodule
